// ### core/dsp_digital_io.v
// Digital I/O port with parallel byte access, serial shifter, strobe, control and status lines.
//
// How it works
// RULE1: eight bidirectional lines form a parallel byte
// RULE2: serial mode uses line4 input, line0 output
// RULE3: strobe gives serial timing or software handshake
// RULE4: eight control outputs follow a writable register
// RULE5: four status inputs are readable by software
// RULE6: parallel write drives output lines at once
// RULE7: parallel read returns present line levels
// RULE8: software does its own parallel handshaking
// RULE9: shift clock from 1.2us, 10us or software
// RULE10: serial input sampled on shift clock rise
// RULE11: sender changes input bit after falling edge
// RULE12: serial output changes on shift clock fall
// RULE13: receiver captures output bit on rising edge
// RULE14: exactly eight shift clock pulses, then stop
// RULE15: software start command begins each byte transfer
// RULE16: serial input and output run together
// RULE17: direction bit one means output, per line
// RULE18: strobe follows software bit or shift clock
// RULE19: bytes shift MSB first, received byte readable
// RULE20: busy flag set during a serial transfer
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "dsp_digital_io_regs.vh"
`default_nettype none

module dsp_digital_io (
    // Clock and reset.
    input  wire       clk,
    input  wire       rst,
    // Register port.
    input  wire [3:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrEn,
    input  wire       regRdEn,
    output reg  [7:0] regRdData,
    // Parallel port lines, split into input, output and enable.
    input  wire [7:0] lineIn,
    output reg  [7:0] lineOut,
    output reg  [7:0] lineOe,
    // Strobe and shift clock output.
    output reg        strobeShiftClock,
    // Board control outputs and status inputs.
    output reg  [7:0] ctrlLines,
    input  wire [3:0] statusLines
);

    // Half period in clock cycles for the selected hardware timebase.
    function [`DSP_DIV_W-1:0] halfCount;
        input [1:0] sel;
        begin
            if (sel == `DSP_TB_SLOW) begin
                halfCount = `DSP_SLOW_HALF;
            end else begin
                halfCount = `DSP_FAST_HALF;
            end
        end
    endfunction

    // Software visible registers.
    reg [7:0]            parOut_q;
    reg [7:0]            dir_q;
    reg                  serEn_q;
    reg [1:0]            tbSel_q;
    reg                  swStrobe_q;
    reg [7:0]            txData_q;
    reg [7:0]            rxData_q;

    // Serial engine state.
    reg                  busy_q;
    reg [2:0]            bitCnt_q;
    reg [7:0]            txShift_q;
    reg [7:0]            rxShift_q;
    reg                  serBit_q;
    reg                  hwClk_q;
    reg [`DSP_DIV_W-1:0] div_q;

    // Input synchronisers for pins from outside the clock domain.
    reg [7:0]            lineMeta_q;
    reg [7:0]            lineSync_q;
    reg [3:0]            statMeta_q;
    reg [3:0]            statSync_q;

    // Decoded strobes.
    wire wrCtrl = regWrEn & (regAddr == `DSP_REG_SER_CTRL);
    wire startReq = wrCtrl & regWrData[`DSP_SC_START] & regWrData[`DSP_SC_SER_EN] & ~busy_q;

    // Hardware timebase is active only in serial mode with a periodic source.
    wire hwTimed = serEn_q & (tbSel_q != `DSP_TB_SOFT);
    wire divTick = busy_q & hwTimed & (div_q == halfCount(tbSel_q) - 1'b1);

    // Level the strobe pin takes next cycle; edges are found against the current pin.
    wire strobeNext = hwTimed ? hwClk_q : swStrobe_q; // RULE18
    wire shiftFall = busy_q & strobeShiftClock & ~strobeNext;
    wire shiftRise = busy_q & ~strobeShiftClock & strobeNext;
    wire lastBit = (bitCnt_q == `DSP_BITS_PER_XFER);

    // Serial input comes from the synchronised copy only.
    wire serIn = lineSync_q[`DSP_SER_IN_LINE];

    // Two flip-flop synchronisers; the first stage feeds only the second.
    always @(posedge clk) begin
        if (rst) begin
            lineMeta_q <= `DSP_RST_BYTE;
            lineSync_q <= `DSP_RST_BYTE;
            statMeta_q <= 4'h0;
            statSync_q <= 4'h0;
        end else begin
            lineMeta_q <= lineIn;
            lineSync_q <= lineMeta_q;
            statMeta_q <= statusLines;
            statSync_q <= statMeta_q;
        end
    end

    // Configuration and data registers written by software.
    // Mode and timebase are frozen while a transfer runs, so a byte never changes clock mid-way.
    always @(posedge clk) begin
        if (rst) begin
            parOut_q   <= `DSP_RST_BYTE;
            dir_q      <= `DSP_RST_BYTE;
            serEn_q    <= 1'b0;
            tbSel_q    <= `DSP_RST_TB;
            swStrobe_q <= `DSP_RST_STROBE;
            txData_q   <= `DSP_RST_BYTE;
            ctrlLines  <= `DSP_RST_BYTE;
        end else if (regWrEn) begin
            case (regAddr)
                `DSP_REG_PAR_OUT: begin
                    parOut_q <= regWrData; // RULE6
                end
                `DSP_REG_DIR: begin
                    dir_q <= regWrData; // RULE17
                end
                `DSP_REG_SER_CTRL: begin
                    swStrobe_q <= regWrData[`DSP_SC_SW_STROBE]; // RULE3
                    if (!busy_q) begin
                        serEn_q <= regWrData[`DSP_SC_SER_EN];
                        tbSel_q <= regWrData[`DSP_SC_TB_HI:`DSP_SC_TB_LO]; // RULE9
                    end
                end
                `DSP_REG_SER_TX: begin
                    txData_q <= regWrData;
                end
                `DSP_REG_CTRL_OUT: begin
                    ctrlLines <= regWrData; // RULE4
                end
                default: begin
                    parOut_q <= parOut_q;
                end
            endcase
        end
    end

    // Divider for the periodic shift clock; it idles high and restarts with each byte.
    always @(posedge clk) begin
        if (rst) begin
            div_q   <= {`DSP_DIV_W{1'b0}};
            hwClk_q <= 1'b1;
        end else if (startReq || !busy_q || !hwTimed) begin
            div_q   <= {`DSP_DIV_W{1'b0}};
            hwClk_q <= 1'b1;
        end else if (divTick) begin
            div_q   <= {`DSP_DIV_W{1'b0}};
            hwClk_q <= ~hwClk_q; // RULE9
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Serial engine: one falling and one rising edge per bit, eight bits per start.
    always @(posedge clk) begin
        if (rst) begin
            busy_q    <= 1'b0;
            bitCnt_q  <= 3'h0;
            txShift_q <= `DSP_RST_BYTE;
            rxShift_q <= `DSP_RST_BYTE;
            rxData_q  <= `DSP_RST_BYTE;
            serBit_q  <= 1'b0;
        end else if (startReq) begin
            busy_q    <= 1'b1; // RULE15 RULE20
            bitCnt_q  <= 3'h0;
            txShift_q <= txData_q;
        end else begin
            if (shiftFall) begin
                // Most significant bit leaves first.
                serBit_q  <= txShift_q[7]; // RULE12 RULE19
                txShift_q <= {txShift_q[6:0], 1'b0};
            end
            if (shiftRise) begin
                // Input and output share this clock within one transfer.
                rxShift_q <= {rxShift_q[6:0], serIn}; // RULE10 RULE16
                bitCnt_q  <= bitCnt_q + 1'b1;
                if (lastBit) begin
                    busy_q   <= 1'b0; // RULE14 RULE20
                    rxData_q <= {rxShift_q[6:0], serIn}; // RULE19
                end
            end
        end
    end

    // Pin drivers; serial mode takes line 0 as output and line 4 as input.
    always @(posedge clk) begin
        if (rst) begin
            lineOut          <= `DSP_RST_BYTE;
            lineOe           <= `DSP_RST_BYTE;
            strobeShiftClock <= `DSP_RST_STROBE;
        end else begin
            strobeShiftClock <= strobeNext; // RULE3 RULE18
            lineOut          <= parOut_q; // RULE1 RULE6
            lineOe           <= dir_q; // RULE17
            if (serEn_q) begin
                lineOut[`DSP_SER_OUT_LINE] <= shiftFall ? txShift_q[7] : serBit_q; // RULE2 RULE12
                lineOe[`DSP_SER_OUT_LINE]  <= 1'b1; // RULE2
                lineOe[`DSP_SER_IN_LINE]   <= 1'b0; // RULE2
            end
        end
    end

    // Read data appear the cycle after the read strobe; unmapped offsets read zero.
    always @(posedge clk) begin
        if (rst) begin
            regRdData <= `DSP_RST_BYTE;
        end else if (regRdEn) begin
            case (regAddr)
                `DSP_REG_PAR_OUT: begin
                    regRdData <= parOut_q;
                end
                `DSP_REG_PAR_IN: begin
                    regRdData <= lineSync_q; // RULE7
                end
                `DSP_REG_DIR: begin
                    regRdData <= dir_q;
                end
                `DSP_REG_SER_CTRL: begin
                    regRdData <= {2'h0, busy_q, 1'b0, swStrobe_q, tbSel_q, serEn_q}; // RULE20
                end
                `DSP_REG_SER_TX: begin
                    regRdData <= txData_q;
                end
                `DSP_REG_SER_RX: begin
                    regRdData <= rxData_q; // RULE19
                end
                `DSP_REG_CTRL_OUT: begin
                    regRdData <= ctrlLines;
                end
                `DSP_REG_STATUS_IN: begin
                    regRdData <= {4'h0, statSync_q}; // RULE5
                end
                default: begin
                    regRdData <= 8'h00;
                end
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule // dsp_digital_io

`default_nettype wire

// ### core/dsp_digital_io_regs.vh
// Register offsets, field positions, reset values and timing counts of the digital I/O port.
`ifndef DSP_DIGITAL_IO_REGS_VH
`define DSP_DIGITAL_IO_REGS_VH

// Register offsets on the 4-bit register address.
`define DSP_REG_PAR_OUT   4'h0
`define DSP_REG_PAR_IN    4'h1
`define DSP_REG_DIR       4'h2
`define DSP_REG_SER_CTRL  4'h3
`define DSP_REG_SER_TX    4'h4
`define DSP_REG_SER_RX    4'h5
`define DSP_REG_CTRL_OUT  4'h6
`define DSP_REG_STATUS_IN 4'h7

// Serial control register fields.
`define DSP_SC_SER_EN     0
`define DSP_SC_TB_LO      1
`define DSP_SC_TB_HI      2
`define DSP_SC_SW_STROBE  3
`define DSP_SC_START      4
`define DSP_SC_BUSY       5

// Shift clock timebase selections.
`define DSP_TB_FAST       2'h0
`define DSP_TB_SLOW       2'h1
`define DSP_TB_SOFT       2'h2

// Reset values.
`define DSP_RST_BYTE      8'h00
`define DSP_RST_TB        2'h0
`define DSP_RST_STROBE    1'b1

// Line positions of the serial pins.
`define DSP_SER_OUT_LINE  0
`define DSP_SER_IN_LINE   4

// Timing: clock rate and the two shift clock periods.
`define DSP_CLK_MHZ       125
`define DSP_FAST_PER_NS   1200
`define DSP_SLOW_PER_NS   10000
// Half periods in clock cycles, sized to the divider: 600 ns and 5000 ns at 125 MHz.
`define DSP_FAST_HALF     10'h04b
`define DSP_SLOW_HALF     10'h271
`define DSP_DIV_W         10
`define DSP_BITS_PER_XFER 3'h7

`endif

// ### dv/dsp_serial_peer.sv
// Serial peripheral model on the shift clock and the two serial data lines.
`default_nettype none
module dsp_serial_peer (
    // Bench clock, load request and byte to send.
    input  wire logic       clk,
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    // Shift clock and data lines of the port.
    input  wire logic       sck,
    input  wire logic       sdo,
    output var  logic       sdi,
    output var  logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh = 8'h00;
    logic       sckQ = 1'b1;
    // Start from a pulled-up data line and an empty capture.
    initial begin
        sdi = 1'b1;
        rxByte = 8'h00;
    end
    // Edges are found late, on the bench clock, as a slow peripheral would see them.
    always @(posedge clk) begin
        sckQ <= sck;
        if (load) begin
            sh <= txByte;
        end else if (sckQ && !sck) begin
            sdi <= sh[7];
            sh <= {sh[6:0], 1'b1};
        end
        if (!sckQ && sck) begin
            rxByte <= {rxByte[6:0], sdo};
        end
    end
endmodule // dsp_serial_peer
`default_nettype wire

// ### dv/dsp_digital_io_sva.sv
// Assertions on the pins and register port of the digital I/O port.
`include "dsp_digital_io_regs.vh"
`default_nettype none
module dsp_digital_io_sva (
    // Clock, reset and register port.
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    // Port pins.
    input wire logic [7:0] lineIn,
    input wire logic [7:0] lineOut,
    input wire logic [7:0] lineOe,
    input wire logic       strobeShiftClock,
    input wire logic [7:0] ctrlLines,
    input wire logic [3:0] statusLines
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] fallCnt_q;
    logic       scWr;
    assign scWr = regWrEn && regAddr == `DSP_REG_SER_CTRL;
    // Falls since the last serial control write; a hardware transfer may not pass eight.
    always @(posedge clk) begin
        if (rst || scWr)
            fallCnt_q <= 4'h0;
        else if ($fell(strobeShiftClock))
            fallCnt_q <= fallCnt_q + 4'h1;
    end
    a_read_idle: assert property (!regRdEn |=> regRdData == 8'h00) else $error("read data not idle");
    a_ctrl_follow: assert property (regWrEn && regAddr == `DSP_REG_CTRL_OUT
        |=> ctrlLines == $past(regWrData)) else $error("control lines wrong");
    a_dir_follow: assert property (regWrEn && regAddr == `DSP_REG_DIR
        |-> ##2 {lineOe[7:5], lineOe[3:1]} == {$past(regWrData[7:5], 2), $past(regWrData[3:1], 2)})
        else $error("bad dir");
    a_par_drive: assert property (regWrEn && regAddr == `DSP_REG_PAR_OUT
        |-> ##2 lineOut[7:1] == $past(regWrData[7:1], 2)) else $error("parallel out wrong");
    a_tx_on_fall: assert property ($changed(lineOut[0])
        |-> $fell(strobeShiftClock) || $past(regWrEn) || $past(regWrEn, 2)) else $error("serial out moved off a fall");
    a_eight_pulses: assert property (fallCnt_q <= 4'h8) else $error("too many shift pulses");
    a_serial_pins: assert property ($fell(strobeShiftClock) && !$past(regWrEn, 2)
        |-> lineOe[0] && !lineOe[4]) else $error("serial pin directions wrong");
    a_soft_strobe: assert property (scWr && regWrData[2:1] == `DSP_TB_SOFT
        |-> ##2 strobeShiftClock == $past(regWrData[3], 2)) else $error("strobe not following bit");
    c_eight: cover property (fallCnt_q == 4'h8);
    c_soft: cover property (scWr && regWrData[2:1] == `DSP_TB_SOFT);
    c_hw_fall: cover property ($fell(strobeShiftClock) && !$past(regWrEn, 2));
endmodule // dsp_digital_io_sva
bind dsp_digital_io dsp_digital_io_sva chk (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .strobeShiftClock(strobeShiftClock), .ctrlLines(ctrlLines), .statusLines(statusLines));
`default_nettype wire

// ### dv/dsp_digital_io_bench.sv
// Self-checking bench for the digital I/O port.
`include "dsp_digital_io_regs.vh"
`default_nettype none
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module dsp_digital_io_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, load = 1'b0, sdi, strobe;
    logic [3:0]  regAddr = 4'h0, statusLines = 4'h9;
    logic [7:0]  regWrData = 8'h00, peerTx = 8'h00, extIn = 8'h3c, regRdData, lineIn, lineOut, lineOe, ctrlLines, rxByte;
    int          cyc = 0, miscompares = 0, cmpCount = 0;
    // Rows: write address, write data, read address, expected read data.
    logic [23:0] rows [7] = '{24'h2f02f0, 24'h0a51ac, 24'h65a65a, 24'h44b44b, 24'h7ff709, 24'h5ee500, 24'hf77f00};
    // Each line is driven by the port where enabled, otherwise by the outside world.
    assign lineIn = (lineOe & lineOut) | (~lineOe & {extIn[7:5], sdi, extIn[3:0]});
    dsp_digital_io uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
        .strobeShiftClock(strobe), .ctrlLines(ctrlLines), .statusLines(statusLines));
    dsp_serial_peer peer (.clk(clk), .load(load), .txByte(peerTx), .sck(strobe), .sdo(lineOut[0]), .sdi(sdi),
        .rxByte(rxByte));
    // Clock and a hang limit well beyond the longest run.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            reportAndStop();
        end
    end
    task automatic reportAndStop();
        $display("compares %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
    // One byte each way; a refused second start must not stretch the run.
    task automatic xfer(input logic [7:0] ctl, input logic [7:0] tx, input int lo, input int hi);
        int t0;
        logic [7:0] d;
        peerTx <= ~tx;
        load <= 1'b1;
        wr(`DSP_REG_SER_TX, tx);
        load <= 1'b0;
        t0 = cyc;
        wr(`DSP_REG_SER_CTRL, ctl);
        rd(`DSP_REG_SER_CTRL, d);
        `CHK("busy", 1'b1, d[5])
        wr(`DSP_REG_SER_CTRL, 8'h1b);
        for (int i = 0; i < 8 && ctl[2:1] == `DSP_TB_SOFT; i++) begin
            repeat (4) @(posedge clk);
            wr(`DSP_REG_SER_CTRL, 8'h05);
            repeat (4) @(posedge clk);
            wr(`DSP_REG_SER_CTRL, 8'h0d);
        end
        do rd(`DSP_REG_SER_CTRL, d); while (d[5] && cyc - t0 < 12000);
        `CHK("duration", 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
        rd(`DSP_REG_SER_RX, d);
        `CHK("serial rx", ~tx, d)
        `CHK("peer rx", tx, rxByte)
    endtask
    initial begin
        logic [7:0] d;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`DSP_REG_SER_CTRL, d);
        `CHK("ctrl reset", 8'h08, d)
        `CHK("oe reset", 8'h00, lineOe)
        foreach (rows[i]) begin
            wr(rows[i][23:20], rows[i][19:12]);
            repeat (3) @(posedge clk);
            rd(rows[i][11:8], d);
            `CHK("row read", rows[i][7:0], d)
        end
        `CHK("ctrl lines", 8'h5a, ctrlLines)
        wr(`DSP_REG_SER_CTRL, 8'h00);
        // The strobe pin is registered behind the strobe bit, so it moves one cycle after the write lands.
        @(posedge clk);
        @(negedge clk);
        `CHK("strobe low", 1'b0, strobe)
        wr(`DSP_REG_SER_CTRL, 8'h08);
        xfer(8'h11, 8'h97, 1180, 1230);
        xfer(8'h13, 8'h4b, 9980, 10040);
        xfer(8'h1d, 8'h4b, 0, 400);
        reportAndStop();
    end
endmodule // dsp_digital_io_bench
`default_nettype wire
